// file: rtl/flood_repeater_forwarding.sv
// Forwarding core of a flooding repeater node: buffers each received packet,
// filters duplicates, delivers to the serial side, repeats after a backoff.
// Assumes the radio presents one packet at a time, all inputs synchronous to pclk.
`timescale 1ns/1ns
module flood_repeater_forwarding
  import flood_fwd_pkg::*;
#(
  parameter int BUF_BYTES = MAX_PKT_BYTES,
  parameter int AIR_W     = 20
) (
  input  wire logic        pclk,            // Clock
  input  wire logic        presetn,         // Async reset, low active
  input  wire logic        ce,              // Clock enable
  input  wire logic [7:0]  paddr,           // APB address
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        rx_start,        // Radio packet begins
  input  wire rx_hdr_t     rx_hdr,          // Header, valid with rx_start
  input  wire logic        rx_byte_valid,   // Payload byte strobe
  input  wire logic [7:0]  rx_byte,         // Payload byte
  input  wire logic        rx_end,          // Packet complete
  output logic             ser_valid,       // Serial delivery valid
  output stream_t          ser_out,         // Serial delivery byte
  input  wire logic        ser_ready,       // Serial side accepts
  output logic             rpt_valid,       // Repeat byte valid
  output stream_t          rpt_out,         // Repeat byte
  output rx_hdr_t          rpt_hdr,         // Header of repeated packet
  input  wire logic        rpt_ready,       // Radio accepts repeat byte
  input  wire logic        local_tx_done,   // Host data was sent on air
  output logic             local_tx_permit  // Host data may be sent
);

  initial begin
    if (BUF_BYTES < 1 || BUF_BYTES > MAX_PKT_BYTES)
      $error("BUF_BYTES out of range");
    if (AIR_W < 8 || AIR_W > 24)
      $error("AIR_W out of range");
  end

  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_RECV   = 6'b000010,
    S_CHECK  = 6'b000100,
    S_SERIAL = 6'b001000,
    S_WAIT   = 6'b010000,
    S_REPEAT = 6'b100000
  } state_t;

  state_t        state_r;
  logic [2:0]    role_r;
  logic          base_r;
  logic [2:0]    rate_r;
  logic [7:0]    slot_set_r;
  logic [15:0]   own_addr_r;
  logic [11:0]   maxpkt_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic [7:0]    dup_cnt_r;
  logic [7:0]    ovf_cnt_r;
  logic [7:0]    buf_mem [BUF_BYTES];
  logic [11:0]   len_r;
  logic          ovf_r;
  logic [11:0]   rd_ptr_r;
  rx_hdr_t       hdr_r;
  logic [AIR_W-1:0] air_cnt_r;
  logic [AIR_W-1:0] air_r;
  pkt_id_t       hist_r [HIST_DEPTH];
  logic [HIST_DEPTH-1:0] hist_vld_r;
  logic [1:0]    hist_wr_r;
  logic          do_rpt_r;
  logic [13:0]   wait_slots_r;
  logic [AIR_W-1:0] wait_cyc_r;
  logic [13:0]   hold_slots_r;
  logic [AIR_W-1:0] hold_cyc_r;
  logic          credit_r;
  logic          permit_r;
  logic [15:0]   lfsr_r;
  logic          ser_valid_r;
  logic          rpt_valid_r;
  stream_t       out_r;

  // ==========================================================
  // APB slave, zero wait states; read data captured in setup phase
  logic          setup;
  logic          wr_acc;
  logic          mapped;
  logic [31:0]   rd_val;
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_r;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:   rd_val = {25'h0, rate_r, base_r, role_r};
      OFS_SLOT:   rd_val = {24'h0, slot_set_r};
      OFS_OWN:    rd_val = {16'h0, own_addr_r};
      OFS_MAXPKT: rd_val = {20'h0, maxpkt_r};
      OFS_STATUS: rd_val = {20'h0, permit_r, credit_r, hist_vld_r, state_r};
      OFS_DROPS:  rd_val = {16'h0, ovf_cnt_r, dup_cnt_r};
      default:    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r <= 1'b1;
      if (setup) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_r <= !mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_r     <= ROLE_RST;
      base_r     <= 1'b0;
      rate_r     <= RATE_RST;
      slot_set_r <= SLOT_RST;
      own_addr_r <= OWN_RST;
      maxpkt_r   <= MAXPKT_RST;
    end else if (ce && wr_acc) begin
      case (paddr)
        OFS_CTRL: begin
          role_r <= pwdata[CTRL_ROLE_LSB +: 3];
          base_r <= pwdata[CTRL_BASE_BIT];
          rate_r <= pwdata[CTRL_RATE_LSB +: 3];
        end
        OFS_SLOT:   slot_set_r <= pwdata[7:0];
        OFS_OWN:    own_addr_r <= pwdata[15:0];
        OFS_MAXPKT: maxpkt_r   <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Decision terms for the packet held in the buffer
  logic          dup_hit;
  logic          is_global;
  logic          is_local;
  logic [11:0]   len_limit;
  logic signed [9:0] rssi_diff;
  logic [4:0]    rssi_term;
  logic [8:0]    rand_slot;
  logic [13:0]   rpt_slots;
  logic [13:0]   resp_slots;

  always_comb begin
    dup_hit = 1'b0;
    for (int i = 0; i < HIST_DEPTH; i++) begin
      if (hist_vld_r[i] && hist_r[i] == pkt_id_t'({hdr_r.src, hdr_r.seq}))
        dup_hit = 1'b1;
    end
  end

  assign is_global = hdr_r.dst == GLOBAL_ADDR;
  assign is_local  = hdr_r.dst == own_addr_r;
  // Full buffer depth at the lowest air rate; the size setting is capped so no write wraps
  assign len_limit = (rate_r == RATE_LOWEST || maxpkt_r > 12'(BUF_BYTES)) ? 12'(BUF_BYTES)
                                                                         : maxpkt_r;

  always_comb begin
    rssi_diff = RSSI_REF - $signed({{2{hdr_r.rssi[7]}}, hdr_r.rssi});
    // Stronger signal gives a smaller difference, hence fewer slots
    rssi_term = rssi_diff[9] ? 5'h00 : 5'(rssi_diff[8:0] / RSSI_STEP[8:0]);
    rand_slot = {1'b0, lfsr_r[7:0]} % ({1'b0, slot_set_r} + 9'h001);
    rpt_slots = 14'(rssi_term * slot_set_r) + 14'(rand_slot);
    resp_slots = 14'(RESP_MUL * slot_set_r) + 14'(slot_set_r) + 14'h0001;
  end

  // ==========================================================
  // Free-running pseudo-random source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lfsr_r <= 16'hACE1;
    else if (ce)
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  // ==========================================================
  // Output stream engine, shared by serial delivery and repeat
  logic          tgt_ready;
  logic          tgt_valid;
  logic          streaming;
  logic          load;
  logic          stream_done;
  assign streaming   = state_r == S_SERIAL || state_r == S_REPEAT;
  assign tgt_ready   = (state_r == S_SERIAL) ? ser_ready : rpt_ready;
  assign tgt_valid   = ser_valid_r || rpt_valid_r;
  assign load        = streaming && rd_ptr_r < len_r && (!tgt_valid || tgt_ready);
  assign stream_done = streaming && rd_ptr_r == len_r && (!tgt_valid || tgt_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_valid_r <= 1'b0;
      rpt_valid_r <= 1'b0;
      out_r       <= '0;
      rd_ptr_r    <= 12'h000;
    end else if (ce) begin
      if (!streaming) begin
        rd_ptr_r    <= 12'h000;
        ser_valid_r <= 1'b0;
        rpt_valid_r <= 1'b0;
      end else if (load) begin
        out_r.data  <= buf_mem[rd_ptr_r[10:0]];
        out_r.last  <= rd_ptr_r == len_r - 12'h001;
        rd_ptr_r    <= rd_ptr_r + 12'h001;
        ser_valid_r <= state_r == S_SERIAL;
        rpt_valid_r <= state_r == S_REPEAT;
      end else if (tgt_ready) begin
        ser_valid_r <= 1'b0;
        rpt_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive buffer; whole packet is stored before any decision
  always_ff @(posedge pclk) begin
    if (ce && state_r == S_RECV && rx_byte_valid && len_r < len_limit)
      buf_mem[len_r[10:0]] <= rx_byte;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r     <= 12'h000;
      ovf_r     <= 1'b0;
      hdr_r     <= '0;
      air_cnt_r <= '0;
      air_r     <= '0;
    end else if (ce) begin
      if (state_r == S_IDLE && rx_start) begin
        len_r     <= 12'h000;
        ovf_r     <= 1'b0;
        hdr_r     <= rx_hdr;
        air_cnt_r <= '0;
      end else if (state_r == S_RECV) begin
        // Receive duration stands in for the packet air time
        if (air_cnt_r != '1)
          air_cnt_r <= air_cnt_r + 1'b1;
        if (rx_byte_valid) begin
          if (len_r < len_limit)
            len_r <= len_r + 12'h001;
          else
            ovf_r <= 1'b1;
        end
        if (rx_end)
          air_r <= air_cnt_r;
      end
    end
  end

  // ==========================================================
  // Identifier history, oldest entry overwritten when full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_vld_r <= '0;
      hist_wr_r  <= 2'h0;
      for (int i = 0; i < HIST_DEPTH; i++)
        hist_r[i] <= '0;
    end else if (ce && state_r == S_CHECK && !dup_hit && !ovf_r) begin
      hist_r[hist_wr_r]     <= pkt_id_t'({hdr_r.src, hdr_r.seq});
      hist_vld_r[hist_wr_r] <= 1'b1;
      hist_wr_r             <= hist_wr_r + 2'h1;
    end
  end

  // ==========================================================
  // Forwarding sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= S_IDLE;
      do_rpt_r     <= 1'b0;
      wait_slots_r <= 14'h0000;
      wait_cyc_r   <= '0;
      dup_cnt_r    <= 8'h00;
      ovf_cnt_r    <= 8'h00;
    end else if (ce) begin
      case (state_r)
        S_IDLE:
          if (rx_start)
            state_r <= S_RECV;
        S_RECV:
          if (rx_end)
            state_r <= S_CHECK;
        S_CHECK: begin
          wait_slots_r <= rpt_slots;
          wait_cyc_r   <= air_r;
          // Global packets repeat only in role 5; role 6 never repeats
          do_rpt_r     <= is_global && role_r == ROLE_REPEATER;
          if (ovf_r) begin
            ovf_cnt_r <= ovf_cnt_r + 8'h01;
            state_r   <= S_IDLE;
          end else if (dup_hit) begin
            dup_cnt_r <= dup_cnt_r + 8'h01;
            state_r   <= S_IDLE;
          end else if (is_global || is_local) begin
            state_r <= S_SERIAL;
          end else begin
            state_r <= S_IDLE;
          end
        end
        S_SERIAL:
          if (stream_done)
            state_r <= do_rpt_r ? S_WAIT : S_IDLE;
        S_WAIT:
          if (wait_slots_r == 14'h0000) begin
            state_r <= S_REPEAT;
          end else if (wait_cyc_r == '0) begin
            wait_cyc_r   <= air_r;
            wait_slots_r <= wait_slots_r - 14'h0001;
          end else begin
            wait_cyc_r <= wait_cyc_r - 1'b1;
          end
        S_REPEAT:
          if (stream_done)
            state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Response hold-off and origination permission
  logic          hold_idle;
  logic          delivered;
  assign hold_idle = hold_slots_r == 14'h0000;
  assign delivered = state_r == S_CHECK && !ovf_r && !dup_hit && (is_global || is_local);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_slots_r <= 14'h0000;
      hold_cyc_r   <= '0;
    end else if (ce) begin
      // Any received traffic restarts the worst-case hold-off
      if (state_r == S_RECV && rx_end) begin
        hold_slots_r <= resp_slots;
        hold_cyc_r   <= air_cnt_r;
      end else if (!hold_idle) begin
        if (hold_cyc_r == '0) begin
          hold_cyc_r   <= air_r;
          hold_slots_r <= hold_slots_r - 14'h0001;
        end else begin
          hold_cyc_r <= hold_cyc_r - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_r <= 1'b0;
      permit_r <= 1'b0;
    end else if (ce) begin
      // A delivered packet earns one response; new delivery wins over done
      if (delivered)
        credit_r <= 1'b1;
      else if (local_tx_done)
        credit_r <= 1'b0;
      // Non-base nodes need a credit; busy radio also blocks the host
      permit_r <= hold_idle && state_r == S_IDLE && !rx_start
                  && (base_r || credit_r);
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign ser_valid       = ser_valid_r;
  assign ser_out         = out_r;
  assign rpt_valid       = rpt_valid_r;
  assign rpt_out         = out_r;
  assign rpt_hdr         = hdr_r;
  assign local_tx_permit = permit_r;

endmodule

// file: common/flood_fwd_pkg.sv
// Constants and carrier types for the flooding repeater forwarding block.
// Assumes a single pclk domain and an APB3 register bus with 32-bit data.
//
// Contract
// - Accept packets to 2048 bytes at lowest rate
// - Retransmit each message at most once; the code repeats it again once its identifier has left the four-entry history
// - Only base node originates; others only respond
// - Destination 0xFFFF is broadcast, delivered everywhere
// - Specific destination delivered only by matching node
// - Global: serial and repeat; local: serial only
// - Identifier is source address plus sequence number
// - Keep last four identifiers, first-in first-out
// - Drop packets whose identifier is in history
// - Role 5 delivers and repeats qualifying packets
// - Role 6 delivers only, waits before responding
// - Buffer whole packet before repeating it
// - Stronger signal repeats earlier than weaker
// - Backoff is air time times RSSI-based slots
// - Hold back serial input data after traffic
// - Response hold-off uses worst-case slot count
package flood_fwd_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SLOT   = 8'h04;
  localparam logic [7:0] OFS_OWN    = 8'h08;
  localparam logic [7:0] OFS_MAXPKT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DROPS  = 8'h14;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_BASE_BIT = 3;
  localparam int CTRL_RATE_LSB = 4;
  localparam logic [2:0]  ROLE_RST   = 3'h0;
  localparam logic [2:0]  RATE_RST   = 3'h0;
  localparam logic [7:0]  SLOT_RST   = 8'h00;
  localparam logic [15:0] OWN_RST    = 16'hFFFF;
  localparam logic [11:0] MAXPKT_RST = 12'h100;

  // ==========================================================
  // Protocol values
  localparam logic [2:0]  ROLE_REPEATER = 3'h5;
  localparam logic [2:0]  ROLE_DEST     = 3'h6;
  localparam logic [2:0]  RATE_LOWEST   = 3'h0;
  localparam logic [15:0] GLOBAL_ADDR   = 16'hFFFF;
  localparam int          MAX_PKT_BYTES = 2048;
  localparam int          HIST_DEPTH    = 4;
  localparam logic signed [9:0] RSSI_REF   = -10'sd41;
  localparam logic signed [9:0] RSSI_FLOOR = -10'sd100;
  localparam logic [9:0]  RSSI_STEP     = 10'h00A;
  // Worst-case RSSI slots per slot setting, integer division as in the formula
  localparam logic [3:0]  RESP_MUL = 4'((RSSI_REF - RSSI_FLOOR) / 10'sd10);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0]       src;
    logic [7:0]        seq;
  } pkt_id_t;

  typedef struct packed {
    logic [15:0]       src;
    logic [7:0]        seq;
    logic [15:0]       dst;
    logic signed [7:0] rssi;
  } rx_hdr_t;

  typedef struct packed {
    logic [7:0]        data;
    logic              last;
  } stream_t;

endpackage

// file: tb/flood_fwd_assertions.sv
// Port assertions for the flooding repeater forwarding block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ns
module flood_fwd_assertions
  import flood_fwd_pkg::*;
(
  input wire logic    pclk,            // Clock
  input wire logic    presetn,         // Reset, low active
  input wire logic    rx_byte_valid,   // Payload byte strobe
  input wire logic    rx_end,          // Packet complete
  input wire logic    ser_valid,       // Serial byte valid
  input wire stream_t ser_out,         // Serial byte
  input wire logic    ser_ready,       // Serial accept
  input wire logic    rpt_valid,       // Repeat byte valid
  input wire stream_t rpt_out,         // Repeat byte
  input wire rx_hdr_t rpt_hdr,         // Repeat header
  input wire logic    rpt_ready,       // Repeat accept
  input wire logic    local_tx_permit  // Host may send
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // Stream steps
  sequence s_ser_stall;
    ser_valid && !ser_ready;
  endsequence
  sequence s_rpt_stall;
    rpt_valid && !rpt_ready;
  endsequence
  sequence s_check_gap;
    !ser_valid ##1 !ser_valid;
  endsequence
  a_ser_hold: assert property (s_ser_stall |=> ser_valid && $stable(ser_out))
    else $error("serial byte changed while stalled");
  a_rpt_hold: assert property (s_rpt_stall |=> rpt_valid && $stable(rpt_out))
    else $error("repeat byte changed while stalled");
  a_rpt_global: assert property (rpt_valid |-> rpt_hdr.dst == GLOBAL_ADDR)
    else $error("non-global packet repeated");
  a_no_cut: assert property (rx_byte_valid |-> !rpt_valid)
    else $error("repeat runs while receiving");
  a_ser_first: assert property ($rose(rpt_valid) |-> !ser_valid)
    else $error("repeat started before delivery ended");
  a_check_gap: assert property (rx_end |-> s_check_gap)
    else $error("delivery began before the history check");
  a_permit_idle: assert property (local_tx_permit |-> !ser_valid && !rpt_valid)
    else $error("host permitted while streaming");
  a_holdoff_start: assert property (rx_end |=> !local_tx_permit [*2])
    else $error("host permitted right after a packet");
endmodule
bind flood_repeater_forwarding flood_fwd_assertions i_chk (
  .pclk, .presetn, .rx_byte_valid, .rx_end, .ser_valid, .ser_out, .ser_ready,
  .rpt_valid, .rpt_out, .rpt_hdr, .rpt_ready, .local_tx_permit
);

// file: tb/flood_fwd_peer.sv
// Far-side model: serial host and radio sink, both stalling at random.
// Assumes valid and data hold until accepted.
`timescale 1ns/1ns
module flood_fwd_peer
  import flood_fwd_pkg::*;
(
  input  wire logic    pclk,      // Clock
  input  wire logic    ser_valid, // Serial byte valid
  input  wire stream_t ser_out,   // Serial byte
  output logic         ser_ready, // Serial accept
  input  wire logic    rpt_valid, // Repeat byte valid
  input  wire stream_t rpt_out,   // Repeat byte
  output logic         rpt_ready  // Radio accept
);
  stream_t ser_q[$];
  stream_t rpt_q[$];
  int      cyc = 0;
  int      ser_t = 0;
  int      rpt_t = 0;
  logic    rpt_on = 1'b0;
  // ====
  // Random stalls keep the hold-until-ready path busy
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ser_ready <= 1'($urandom_range(1, 0));
    rpt_ready <= 1'($urandom_range(1, 0));
    rpt_on <= rpt_valid;
    if (rpt_valid && !rpt_on) begin
      rpt_t <= cyc;
    end
    if (ser_valid && ser_ready) begin
      ser_q.push_back(ser_out);
      ser_t <= cyc;
    end
    if (rpt_valid && rpt_ready) begin
      rpt_q.push_back(rpt_out);
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the flooding repeater forwarding block.
// Assumes the peer model sinks both output streams.
`timescale 1ns/1ns
module tb;
  import flood_fwd_pkg::*;
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
  localparam logic [15:0] OWN_A = 16'h0012;
  logic        pclk, presetn, psel, penable, pwrite, rx_start, rx_byte_valid, rx_end;
  logic        pready, pslverr, ser_valid, ser_ready, rpt_valid, rpt_ready, err;
  logic        local_tx_done, local_tx_permit, ce;
  logic [7:0]  paddr, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  role;
  rx_hdr_t     rx_hdr, rpt_hdr;
  stream_t     ser_out, rpt_out;
  logic [7:0]  pay[$];
  logic [7:0]  ra[4] = '{OFS_CTRL, OFS_SLOT, OFS_OWN, OFS_MAXPKT};
  logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0000_0100};
  int          errors, compares, cyc, t_end, gs, gw, n;

  flood_repeater_forwarding i_dut (
    .pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_start, .rx_hdr, .rx_byte_valid, .rx_byte, .rx_end,
    .ser_valid, .ser_out, .ser_ready, .rpt_valid, .rpt_out, .rpt_hdr, .rpt_ready,
    .local_tx_done, .local_tx_permit
  );
  flood_fwd_peer i_peer (
    .pclk, .ser_valid, .ser_out, .ser_ready, .rpt_valid, .rpt_out, .rpt_ready
  );

  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end

  // ====
  // Expectations
  function automatic int min_slots(int r, int rn);
    return ((-41 - r) / 10 > 0 ? (-41 - r) / 10 : 0) * rn;
  endfunction
  function automatic int hold_slots(int rn);
    return ((-41 - (-100)) / 10) * rn + rn + 1;
  endfunction

  // ====
  // Drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sends one packet, waits until idle, then checks both streams
  task automatic pkt(input logic [15:0] s, input logic [7:0] q, input logic [15:0] dst,
                     input int r, input int len, input bit dup);
    bit es;
    bit er;
    es = !dup && (dst == GLOBAL_ADDR || dst == OWN_A);
    er = !dup && dst == GLOBAL_ADDR && role == ROLE_REPEATER;
    pay.delete();
    i_peer.ser_q.delete();
    i_peer.rpt_q.delete();
    @(posedge pclk);
    rx_start <= 1'b1;
    rx_hdr <= '{src: s, seq: q, dst: dst, rssi: 8'(r)};
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      rx_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      pay.push_back(8'($urandom));
      rx_byte <= pay[i];
    end
    @(posedge pclk);
    rx_start <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    t_end = cyc;
    @(posedge pclk);
    rx_end <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 3000);
    `CHK(i_peer.ser_q.size(), es ? len : 0)
    `CHK(i_peer.rpt_q.size(), er ? len : 0)
    foreach (i_peer.ser_q[i]) `CHK(i_peer.ser_q[i], {pay[i], 1'(i == len - 1)})
    foreach (i_peer.rpt_q[i]) `CHK(i_peer.rpt_q[i], {pay[i], 1'(i == len - 1)})
  endtask

  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ====
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, rx_start, rx_byte_valid, rx_end} = '0;
    {paddr, rx_byte, pwdata, rx_hdr, local_tx_done, role} = '0;
    {errors, compares, cyc} = '0;
    ce = 1'b1;
    void'($urandom(90));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    `CHK(local_tx_permit, 1'b0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, OFS_OWN, {16'h0, OWN_A});
    role = ROLE_REPEATER;
    apb(1'b1, OFS_CTRL, {29'h0, role});
    pkt(16'h0001, 8'h01, GLOBAL_ADDR, -50, 5, 0);
    pkt(16'h0001, 8'h01, GLOBAL_ADDR, -50, 5, 1);
    apb(1'b0, OFS_DROPS, 32'h0);
    `CHK(rd[7:0], 8'h01)
    pkt(16'h0002, 8'h01, OWN_A, -50, 1, 0);
    pkt(16'h0003, 8'h01, 16'h0034, -50, 4, 0);
    pkt(16'h0001, 8'h02, GLOBAL_ADDR, -50, 3, 0);
    pkt(16'h0004, 8'h01, GLOBAL_ADDR, -50, 2, 0);
    pkt(16'h0001, 8'h01, GLOBAL_ADDR, -50, 2, 0);
    pkt(16'h0003, 8'h01, GLOBAL_ADDR, -50, 2, 1);
    for (int i = 0; i < 6; i++) begin
      pkt(16'h0100 + 16'(i), 8'($urandom), i[0] ? OWN_A : GLOBAL_ADDR,
          -$urandom_range(60, 41), $urandom_range(24, 1), 0);
    end
    apb(1'b1, OFS_SLOT, 32'h1);
    pkt(16'h0200, 8'h01, GLOBAL_ADDR, -41, 8, 0);
    gs = i_peer.rpt_t - i_peer.ser_t;
    pkt(16'h0201, 8'h01, GLOBAL_ADDR, -121, 8, 0);
    gw = i_peer.rpt_t - i_peer.ser_t;
    `CHK(gw > gs, 1'b1)
    `CHK(gw >= min_slots(-121, 1) * 9, 1'b1)
    `CHK(gs <= (min_slots(-41, 1) + 2) * 10 + 16, 1'b1)
    pkt(16'h0202, 8'h01, OWN_A, -70, 8, 0);
    // A frozen enable must stretch the hold-off by the frozen cycles
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    n = 0;
    while (local_tx_permit !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(cyc - t_end >= hold_slots(1) * 9 + 20, 1'b1)
    `CHK(local_tx_permit, 1'b1)
    local_tx_done <= 1'b1;
    @(posedge pclk);
    local_tx_done <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(local_tx_permit, 1'b0)
    // Faster air rate uses the size setting: an oversized packet is dropped
    apb(1'b1, OFS_MAXPKT, 32'h4);
    apb(1'b1, OFS_CTRL, {25'h0, 3'h1, 1'b0, role});
    pkt(16'h0210, 8'h01, GLOBAL_ADDR, -50, 6, 1);
    apb(1'b0, OFS_DROPS, 32'h0);
    `CHK(rd[15:8], 8'h01)
    role = ROLE_DEST;
    apb(1'b1, OFS_CTRL, {29'h0, role});
    pkt(16'h0300, 8'h01, GLOBAL_ADDR, -60, MAX_PKT_BYTES, 0);
    print_verdict();
  end
endmodule
